// ==== core/capcomp_pkg.sv ====
// Purpose: Shared constants for the one-shot and pulse-width capture timer.
// Assumes: Avalon-MM slave with 32-bit data and word-aligned byte addresses.
// Notes: Register offsets are byte addresses; narrow registers sit low.
package capcomp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] off_mode_ctl = 5'h00; // Mode and overflow flag.
  localparam logic [4:0] off_capcomp_ctl = 5'h04; // Capture source select.
  localparam logic [4:0] off_out_ctl = 5'h08; // Output control.
  localparam logic [4:0] off_count = 5'h0c; // Running count, read only.
  localparam logic [4:0] off_reg_a = 5'h10; // Capture/compare A.
  localparam logic [4:0] off_reg_b = 5'h14; // Capture/compare B.
  localparam logic [4:0] off_prescale = 5'h18; // Count clock divider.
  localparam logic [4:0] off_irq_status = 5'h1c; // Sticky events.
  // Mask shares the status layout; one more word past status.
  localparam logic [5:0] off_irq_mask = 6'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int pos_ovf = 0; // Overflow flag in the mode register.
  localparam int pos_mode_lo = 2; // Operating mode low bit.
  localparam int pos_mode_hi = 3; // Operating mode high bit.
  localparam int pos_sel_b = 0; // Register A capture from input B.
  localparam int pos_a_inv = 1; // Invert output on match A.
  localparam int pos_out_en = 0; // Output enable.
  localparam int pos_b_inv = 4; // Invert output on match B.
  localparam int pos_os_en = 5; // One-shot enable.
  localparam int pos_os_trig = 6; // One-shot software trigger.
  localparam int pos_irq_a = 0; // Status bit of match/capture A.
  localparam int pos_irq_b = 1; // Status bit of match/capture B.
  localparam int pos_irq_ovf = 2; // Status bit of overflow.

  // ----------------------------------------------------------------
  // Reset values and modes
  // ----------------------------------------------------------------
  localparam logic [7:0] rst_byte = 8'h00; // All control bytes.
  localparam logic [15:0] rst_word = 16'h0000; // Count and registers.
  localparam logic [15:0] count_max = 16'hffff; // Wrap point.
  localparam logic [7:0] rst_prescale = 8'h00; // Divide by one.

  typedef enum logic [1:0]
  {
    mode_stop = 2'b00,
    mode_free = 2'b01,
    mode_edge_clear = 2'b10,
    mode_match_clear = 2'b11
  } op_mode_t;

endpackage

// ==== core/edge_sync.sv ====
// Purpose: Two-stage synchroniser with rise and fall detection for a pin.
// Assumes: Pin is asynchronous to ref_clk.
// Notes: The first stage is read only by the second stage.
module edge_sync
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  // ----------------------------------------------------------------
  // Synchroniser and edge history
  // ----------------------------------------------------------------
  logic [2:0] sync_reg; // Stage 0, stage 1, previous stage 1.
  logic [2:0] sync_next; // Next value of the shift chain.

  // Shift the pin through the chain.
  always_comb
  begin
    sync_next = {sync_reg[1:0], pin};
  end

  // Register the chain; the first stage feeds only the second.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_reg <= 3'h0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  // Edges compare the settled stage with its previous value.
  assign rise = sync_reg[1] & ~sync_reg[2];
  assign fall = ~sync_reg[1] & sync_reg[2];

endmodule

// ==== core/capcomp_timer.sv ====
// Purpose: One channel of a 16-bit timer with one-shot compare output
//          and pulse-width capture from two trigger inputs.
// Assumes: Avalon-MM slave on ref_clk; trigger pins are asynchronous.
// Notes: The count clock is ref_clk divided by prescale + 1.
//
// How it works
// - Match A raises irq A in one-shot only; inverts output there, or with A invert set.
// - Match B raises irq B in one-shot only; inverts output there, or with B invert set.
// - Output active after M+1, lasts N-M clocks.
// - Free mode: input A captures B, B captures A.
// - Single input: opposite edge to A, valid to B.
// - Edge-clear mode: valid edge also clears counter.
// - Overflow sets flag; software clears by writing zero.
// - Opposite-edge capture into A raises no irq.
// - A captures from input A or B; B from A.
// - Counter read returns count without disturbing it.
// - One-shot works in modes 01 and 10 only.
// - Soft trigger or valid edge restarts one pulse.
//
// Chosen here: the address map and register access over Avalon-MM.
module capcomp_timer
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  output logic timer_output_pin,
  output logic match_irq_a,
  output logic match_irq_b,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  logic a_rise; // Rising edge on input A.
  logic a_fall; // Falling edge on input A.
  logic b_rise; // Rising edge on input B.
  logic b_fall; // Falling edge on input B.

  edge_sync sync_a
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(trigger_input_a),
    .rise(a_rise),
    .fall(a_fall)
  );

  edge_sync sync_b
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(trigger_input_b),
    .rise(b_rise),
    .fall(b_fall)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mode_control_reg, mode_control_next; // Mode and overflow.
  logic [7:0] capcomp_control_reg, capcomp_control_next; // Capture select.
  logic [7:0] output_control_reg, output_control_next; // Output control.
  logic [7:0] prescaler_mode_reg, prescaler_mode_next; // Divider.
  logic [7:0] presc_cnt_reg, presc_cnt_next; // Divider count.
  logic [15:0] count_register, count_next; // Running count.
  logic [15:0] capcomp_reg_a, capcomp_a_next; // Register A.
  logic [15:0] capcomp_reg_b, capcomp_b_next; // Register B.
  logic [2:0] irq_status_reg, irq_status_next; // Sticky events.
  logic [2:0] irq_mask_reg, irq_mask_next; // Interrupt mask.
  logic out_level_reg, out_level_next; // Timer output level.
  logic os_run_reg, os_run_next; // One-shot counting window.
  logic irq_a_reg, irq_a_next; // Match/capture A pulse.
  logic irq_b_reg, irq_b_next; // Match/capture B pulse.
  logic irq_reg, irq_next; // Combined interrupt level.
  logic [31:0] rdata_reg, rdata_next; // Read data.
  logic wait_reg, wait_next; // Waitrequest.

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  capcomp_pkg::op_mode_t mode; // Current operating mode.
  logic tick; // One count clock.
  logic a_valid; // Valid edge on input A, either rise or fall.
  logic a_opp; // Edge opposite to the valid one on input A.
  logic b_valid; // Valid edge on input B.
  logic os_on; // One-shot allowed in this mode.
  logic os_trig; // One-shot trigger this cycle.
  logic match_a; // Counter equals register A on a tick.
  logic match_b; // Counter equals register B on a tick.
  logic wrap; // Counter wraps on this tick.
  logic take; // Bus access taken this cycle.

  assign mode = capcomp_pkg::op_mode_t'(
    mode_control_reg[capcomp_pkg::pos_mode_hi:capcomp_pkg::pos_mode_lo]);
  assign tick = (presc_cnt_reg == prescaler_mode_reg);
  // Both edges count as valid, which serves the two-input method.
  assign a_valid = a_rise | a_fall;
  // The opposite phase is the falling edge when both-edge detection
  // is not chosen; edge selection bits are outside this block, so
  // rising is the valid edge while the single-input select is set.
  assign a_opp = capcomp_control_reg[2] & a_fall;
  assign b_valid = b_rise | b_fall;
  assign os_on = output_control_reg[capcomp_pkg::pos_os_en] &&
    (mode == capcomp_pkg::mode_free ||
     mode == capcomp_pkg::mode_edge_clear);
  assign match_a = tick && (count_register == capcomp_reg_a);
  assign match_b = tick && (count_register == capcomp_reg_b);
  assign wrap = tick && (mode != capcomp_pkg::mode_stop) &&
    (count_register == capcomp_pkg::count_max);
  assign take = (avs_read | avs_write) & wait_reg;

  // Returns true when the taken write hits the given offset.
  function automatic logic wr_hit(input logic [5:0] off);
    wr_hit = take && avs_write && (avs_address == off);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process computes every next value so that hardware sets and
  // software clears can be ordered plainly: the set is applied last.
  always_comb
  begin
    logic cap_a_valid; // Capture into A on its valid trigger.
    logic cap_a_opp; // Capture into A on the opposite edge.
    logic cap_b; // Capture into B.
    logic a_sel_edge; // Valid input A edge in single-input use.
    logic ev_a; // Interrupt event A.
    logic ev_b; // Interrupt event B.
    cap_a_valid = 1'b0;
    cap_a_opp = 1'b0;
    cap_b = 1'b0;
    a_sel_edge = capcomp_control_reg[2] ? a_rise : a_valid;
    ev_a = 1'b0;
    ev_b = 1'b0;
    mode_control_next = mode_control_reg;
    capcomp_control_next = capcomp_control_reg;
    output_control_next = output_control_reg;
    prescaler_mode_next = prescaler_mode_reg;
    presc_cnt_next = tick ? 8'h00 : presc_cnt_reg + 8'h01;
    count_next = count_register;
    capcomp_a_next = capcomp_reg_a;
    capcomp_b_next = capcomp_reg_b;
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    out_level_next = out_level_reg;
    os_run_next = os_run_reg;
    rdata_next = 32'h0;
    wait_next = 1'b1;

    // Software trigger bit reads back as zero; it only fires once.
    os_trig = os_on && (wr_hit(6'(capcomp_pkg::off_out_ctl)) &&
      avs_writedata[capcomp_pkg::pos_os_trig] ||
      a_sel_edge);

    // Counter runs on each tick outside stop; read does not touch it.
    if (mode == capcomp_pkg::mode_stop)
    begin
      count_next = capcomp_pkg::rst_word;
      os_run_next = 1'b0;
    end
    else if (tick)
    begin
      if (mode == capcomp_pkg::mode_match_clear && match_a)
        count_next = capcomp_pkg::rst_word;
      else
        count_next = count_register + 16'h0001;
    end

    // Captures, only when the register is not used for one-shot.
    if (!os_on && mode != capcomp_pkg::mode_stop)
    begin
      if (capcomp_control_reg[capcomp_pkg::pos_sel_b])
        cap_a_valid = b_valid;
      else
        cap_a_opp = a_opp;
      cap_b = a_sel_edge;
    end
    if (cap_a_valid || cap_a_opp)
      capcomp_a_next = count_register;
    if (cap_b)
      capcomp_b_next = count_register;
    // Edge-clear restarts the counter on the valid edge.
    if (mode == capcomp_pkg::mode_edge_clear && (cap_b || os_trig))
      count_next = capcomp_pkg::rst_word;
    if (os_trig)
    begin
      count_next = capcomp_pkg::rst_word;
      os_run_next = 1'b1;
    end

    // Compare events: in one-shot both matches toggle the output,
    // giving an active level from M+1 to N+1 after the trigger.
    if (os_on && os_run_reg)
    begin
      if (match_a)
      begin
        ev_a = 1'b1;
        out_level_next = ~out_level_next;
      end
      if (match_b)
      begin
        ev_b = 1'b1;
        out_level_next = ~out_level_next;
        os_run_next = 1'b0;
      end
    end
    else if (!os_on && mode != capcomp_pkg::mode_stop)
    begin
      ev_a = cap_a_valid;
      ev_b = cap_b;
      if (match_a && output_control_reg[capcomp_pkg::pos_a_inv])
        out_level_next = ~out_level_next;
      if (match_b && output_control_reg[capcomp_pkg::pos_b_inv])
        out_level_next = ~out_level_next;
    end

    // Bus access: answered one cycle after it is presented.
    if (take)
    begin
      wait_next = 1'b0;
      if (avs_read)
      begin
        case (avs_address)
          capcomp_pkg::off_mode_ctl: rdata_next[7:0] = mode_control_reg;
          capcomp_pkg::off_capcomp_ctl:
            rdata_next[7:0] = capcomp_control_reg;
          capcomp_pkg::off_out_ctl: rdata_next[7:0] = output_control_reg;
          capcomp_pkg::off_count: rdata_next[15:0] = count_register;
          capcomp_pkg::off_reg_a: rdata_next[15:0] = capcomp_reg_a;
          capcomp_pkg::off_reg_b: rdata_next[15:0] = capcomp_reg_b;
          capcomp_pkg::off_prescale: rdata_next[7:0] = prescaler_mode_reg;
          capcomp_pkg::off_irq_status:
          begin
            rdata_next[2:0] = irq_status_reg;
            irq_status_next = 3'h0;
          end
          capcomp_pkg::off_irq_mask: rdata_next[2:0] = irq_mask_reg;
          default: rdata_next = 32'h0;
        endcase
      end
      else
      begin
        case (avs_address)
          capcomp_pkg::off_mode_ctl:
            mode_control_next = avs_writedata[7:0];
          capcomp_pkg::off_capcomp_ctl:
            capcomp_control_next = avs_writedata[7:0];
          capcomp_pkg::off_out_ctl:
            output_control_next = {1'b0, avs_writedata[6:0] &
              7'h3f};
          capcomp_pkg::off_reg_a: capcomp_a_next = avs_writedata[15:0];
          capcomp_pkg::off_reg_b: capcomp_b_next = avs_writedata[15:0];
          capcomp_pkg::off_prescale:
            prescaler_mode_next = avs_writedata[7:0];
          capcomp_pkg::off_irq_mask: irq_mask_next = avs_writedata[2:0];
          default: wait_next = 1'b0;
        endcase
      end
    end

    // Hardware sets win over software clears in the same cycle.
    if (wrap)
    begin
      mode_control_next[capcomp_pkg::pos_ovf] = 1'b1;
      irq_status_next[capcomp_pkg::pos_irq_ovf] = 1'b1;
    end
    if (ev_a)
      irq_status_next[capcomp_pkg::pos_irq_a] = 1'b1;
    if (ev_b)
      irq_status_next[capcomp_pkg::pos_irq_b] = 1'b1;
    irq_a_next = ev_a;
    irq_b_next = ev_b;
    irq_next = |(irq_status_next & ~irq_mask_next);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every state element takes a constant under reset.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_control_reg <= capcomp_pkg::rst_byte;
      capcomp_control_reg <= capcomp_pkg::rst_byte;
      output_control_reg <= capcomp_pkg::rst_byte;
      prescaler_mode_reg <= capcomp_pkg::rst_prescale;
      presc_cnt_reg <= 8'h00;
      count_register <= capcomp_pkg::rst_word;
      capcomp_reg_a <= capcomp_pkg::rst_word;
      capcomp_reg_b <= capcomp_pkg::rst_word;
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h7;
      out_level_reg <= 1'b0;
      os_run_reg <= 1'b0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0;
      wait_reg <= 1'b1;
    end
    else
    begin
      mode_control_reg <= mode_control_next;
      capcomp_control_reg <= capcomp_control_next;
      output_control_reg <= output_control_next;
      prescaler_mode_reg <= prescaler_mode_next;
      presc_cnt_reg <= presc_cnt_next;
      count_register <= count_next;
      capcomp_reg_a <= capcomp_a_next;
      capcomp_reg_b <= capcomp_b_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      out_level_reg <= out_level_next;
      os_run_reg <= os_run_next;
      irq_a_reg <= irq_a_next;
      irq_b_reg <= irq_b_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The pin shows the level directly; the output enable bit does not gate it.
  assign timer_output_pin = out_level_reg;
  assign match_irq_a = irq_a_reg;
  assign match_irq_b = irq_b_reg;
  assign irq = irq_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule

// ==== verif/capcomp_timer_assertions.sv ====
// Purpose: Port-level checks of the capture timer's bus and events.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Bound to every capcomp_timer instance below.
module capcomp_timer_checker
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  input wire logic timer_output_pin,
  input wire logic match_irq_a,
  input wire logic match_irq_b,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Clocking shared by every check
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // A taken request is answered at the very next edge.
  answer_due_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
  // The answer lasts one cycle, so a held request is not taken twice.
  answer_once_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
  // No answer without a request behind it.
  answer_cause_a:
    assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
  // Read data stay zero outside the answer cycle.
  rdata_idle_a:
    assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data outside answer");
  // Each match event is a single-cycle pulse.
  pulse_a_short_a:
    assert property (match_irq_a |=> !match_irq_a)
      else $error("match A pulse too long");
  pulse_b_short_a:
    assert property (match_irq_b |=> !match_irq_b)
      else $error("match B pulse too long");
  // The output only flips beside a match event, one cycle either way.
  pin_cause_a:
    assert property ($changed(timer_output_pin) |->
      (match_irq_a || match_irq_b || $past(match_irq_a || match_irq_b))
      or ##1 (match_irq_a || match_irq_b))
      else $error("output flipped without match");
  // The interrupt only drops after a register access clears it.
  irq_drop_a:
    assert property ($fell(irq) |-> $past(avs_read || avs_write)
      || $past(avs_read || avs_write, 2)
      || $past(avs_read || avs_write, 3))
      else $error("interrupt dropped by itself");
endmodule

bind capcomp_timer capcomp_timer_checker chk
(
  .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest,
  .trigger_input_a, .trigger_input_b, .timer_output_pin,
  .match_irq_a, .match_irq_b, .irq
);

// ==== verif/pulse_source.sv ====
// Purpose: Far-side source of pulses on both trigger inputs.
// Assumes: Pulses start and end on ref_clk edges; lines idle low.
// Notes: Widths stay above two count clocks so both edges are seen.
module pulse_source
(
  input wire logic ref_clk,
  output logic trig_a,
  output logic trig_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines rest low until a pulse is asked for.
  initial
  begin
    trig_a = 1'b0;
    trig_b = 1'b0;
  end
  // One pulse; rise and fall both carry timing, so both are used.
  task automatic pulse(input logic sel_b, input int width);
    @(posedge ref_clk);
    if (sel_b)
      trig_b <= 1'b1;
    else
      trig_a <= 1'b1;
    repeat (width) @(posedge ref_clk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench of the capture timer over Avalon-MM.
// Assumes: Prescale 0, so one count per ref_clk cycle.
// Notes: One overflow costs 65536 cycles; it is waited out once.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v, w;
  logic trigger_input_a, trigger_input_b, timer_output_pin, irq;
  logic match_irq_a, match_irq_b;
  int errors, checks, cnt_a, cnt_b, high;
  localparam logic [5:0] r_mode = 6'(capcomp_pkg::off_mode_ctl);
  localparam logic [5:0] r_cc = 6'(capcomp_pkg::off_capcomp_ctl);
  localparam logic [5:0] r_out = 6'(capcomp_pkg::off_out_ctl);
  localparam logic [5:0] r_cnt = 6'(capcomp_pkg::off_count);
  localparam logic [5:0] r_a = 6'(capcomp_pkg::off_reg_a);
  localparam logic [5:0] r_b = 6'(capcomp_pkg::off_reg_b);
  localparam logic [5:0] r_st = 6'(capcomp_pkg::off_irq_status);
  localparam logic [5:0] r_mask = capcomp_pkg::off_irq_mask;
  capcomp_timer dut
  (
    .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest,
    .trigger_input_a, .trigger_input_b, .timer_output_pin,
    .match_irq_a, .match_irq_b, .irq
  );
  pulse_source src
  (
    .ref_clk, .trig_a(trigger_input_a), .trig_b(trigger_input_b)
  );
  // ------------------------------------------------------------
  // Clock, event counters and watchdog
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Event pulses are counted mid-cycle, where they have settled.
  always @(negedge ref_clk)
  begin
    cnt_a += int'(match_irq_a === 1'b1);
    cnt_b += int'(match_irq_b === 1'b1);
  end
  // About 66000 cycles are needed; this leaves a margin.
  initial
  begin
    #400000;
    errors++;
    $display("wrong value at %0t: watchdog ran out", $time);
    final_report();
  end
  // ------------------------------------------------------------
  // Bus access and comparison tasks
  // ------------------------------------------------------------
  // Holds the request until waitrequest is seen low at an edge.
  task automatic bus(input logic [5:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    // Waitrequest and read data are the values standing at the edge.
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20)
      check_word(32'h1, 32'h0, "no answer");
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic check_word(input logic [31:0] got,
                            input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int exp,
                             input string what);
    check_word(32'(got), 32'(exp), what);
  endtask
  // Stops the counter, clears outputs, loads sentinels, restarts.
  task automatic prep(input logic [31:0] m, input logic [31:0] cc);
    wr(r_mode, 32'h0);
    wr(r_out, 32'h0);
    wr(r_cc, cc);
    wr(r_a, 32'hffff);
    wr(r_b, 32'hffff);
    wr(r_mode, m);
    cnt_a = 0;
    cnt_b = 0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, with 24 unmapped; mask starts all set.
    wr(6'h24, 32'hffffffff);
    for (int i = 0; i < 10; i++)
    begin
      bus(6'(i * 4), 1'b0, 32'h0, v);
      check_word(v, (i == 8) ? 32'h7 : 32'h0, "reset value");
    end
    $display("test reset done");
    // Two reads three cycles apart differ by exactly three.
    wr(r_mode, 32'h04);
    bus(r_cnt, 1'b0, 32'h0, v);
    bus(r_cnt, 1'b0, 32'h0, w);
    check_word(w - v, 32'h3, "count step");
    repeat (65540) @(posedge ref_clk);
    bus(r_mode, 1'b0, 32'h0, v);
    check_word(v & 32'h1, 32'h1, "overflow flag");
    bus(r_st, 1'b0, 32'h0, v);
    check_word(v & 32'h4, 32'h4, "overflow event");
    wr(r_mode, 32'h04);
    bus(r_mode, 1'b0, 32'h0, v);
    check_word(v, 32'h04, "flag cleared");
    // Clear-on-match mode keeps the count at or below register A.
    wr(r_mode, 32'h0);
    wr(r_a, 32'd5);
    wr(r_mode, 32'h0c);
    repeat (20) @(posedge ref_clk);
    bus(r_cnt, 1'b0, 32'h0, v);
    check_count(int'(v <= 32'd5), 1, "count held below A");
    $display("test count done");
    // One-shot in both permitted modes; A=8, B=14, active for 6.
    wr(r_mask, 32'h6);
    for (int i = 1; i < 3; i++)
    begin
      wr(r_mode, 32'h0);
      wr(r_a, 32'd8);
      wr(r_b, 32'd14);
      wr(r_out, 32'h32);
      wr(r_mode, 32'(i * 4));
      cnt_a = 0;
      cnt_b = 0;
      high = 0;
      wr(r_out, 32'h72);
      repeat (40)
      begin
        @(negedge ref_clk);
        high += int'(timer_output_pin === 1'b1);
      end
      check_count(high, 6, "active width");
      check_count(cnt_a, 1, "match A");
      check_count(cnt_b, 1, "match B");
    end
    // Lower B right after its match, then fire again: width drops to 4.
    wr(r_b, 32'd12);
    high = 0;
    wr(r_out, 32'h72);
    repeat (40)
    begin
      @(negedge ref_clk);
      high += int'(timer_output_pin === 1'b1);
    end
    check_count(high, 4, "shorter width");
    check_word(32'(irq), 32'h1, "irq raised");
    bus(r_st, 1'b0, 32'h0, v);
    check_word(v & 32'h3, 32'h3, "status");
    repeat (3) @(negedge ref_clk);
    check_word(32'(irq), 32'h0, "irq cleared");
    wr(r_mask, 32'h7);
    $display("test one-shot done");
    // Two inputs, free mode: A fills B, B fills A.
    prep(32'h04, 32'h01);
    src.pulse(1'b0, 10);
    repeat (6) @(posedge ref_clk);
    bus(r_a, 1'b0, 32'h0, v);
    check_word(v, 32'hffff, "A untouched");
    src.pulse(1'b1, 10);
    repeat (6) @(posedge ref_clk);
    bus(r_a, 1'b0, 32'h0, v);
    bus(r_b, 1'b0, 32'h0, w);
    check_count(int'(v != 32'hffff), 1, "A from B");
    check_count(int'(w != 32'hffff), 1, "B from A");
    check_count(cnt_b, 2, "B events");
    check_word(v - w, 32'd20, "B fall to A fall");
    // Single input: fall fills A silently, rise fills B.
    prep(32'h04, 32'h04);
    src.pulse(1'b0, 12);
    repeat (6) @(posedge ref_clk);
    bus(r_a, 1'b0, 32'h0, v);
    bus(r_b, 1'b0, 32'h0, w);
    check_word(v - w, 32'd12, "high width");
    check_count(cnt_a, 0, "no A event");
    check_count(cnt_b, 1, "B event");
    // Edge-clear mode: period 21 from rise, A from the new clear.
    prep(32'h08, 32'h04);
    src.pulse(1'b0, 12);
    repeat (8) @(posedge ref_clk);
    src.pulse(1'b0, 12);
    repeat (6) @(posedge ref_clk);
    bus(r_a, 1'b0, 32'h0, v);
    bus(r_b, 1'b0, 32'h0, w);
    check_word(w - v, 32'd9, "period less width");
    $display("test capture done");
    final_report();
  end
endmodule
